// ===== rtl/monitor_mode_entry_link.sv
`timescale 1ns/10ps
`default_nettype none
`include "monitor_mode_entry_link_map.svh"

// Summary of operation
// [R1] Latch monitor decision at reset pin rise.
// [R2] Host supplies test voltage and matching clock.
// [R3] Erased-vector entry divides bus clock by four.
// [R4] Test entry divides by two or four.
// [R5] Test entry with select low bypasses halving.
// [R6] Erased-vector entry ignores straps and select.
// [R7] Erased-vector entry issues one extra reset.
// [R8] Erased-vector entry disables watchdog permanently.
// [R9] Test entry disables watchdog while voltage present.
// [R10] Host may move test voltage to reset.
// [R11] Wait eight security bytes, then send break.
// [R12] Monitor mode uses the 0xFE vector page.
// [R13] Erased-vector mode exits only at power-on.
// [R14] NRZ framing, same rate both directions.
// [R15] Break is start plus nine zero bits.
// [R16] On break, hold high two bits, echo.
// [R17] Reset pin low stops bus clock, operation.
// [R18] Baud divisor 1024, or 512 select low.
// [R19] Serial pin is open-drain with pull-up; the code drives it high during the break hold.
// [R20] Capture all entry conditions together at release.

module monitor_mode_entry_link
   import monitor_mode_entry_link_pkg::*;
(
   // Clock and power-on reset.
   input  wire logic                               clk_i,
   input  wire logic                               resetn_i,
   // Entry pins and flash state.
   input  wire logic                               ext_reset_pin_i,
   input  wire logic                               reset_pin_test_voltage_i,
   input  wire logic                               entry_interrupt_pin_i,
   input  wire logic                               entry_interrupt_test_voltage_i,
   input  wire logic                               divider_select_pin_i,
   input  wire logic                               entry_strap_high_pin_i,
   input  wire logic                               entry_strap_low_pin_i,
   input  wire logic                               reset_vector_erased_i,
   // Single-wire link.
   input  wire logic                               monitor_serial_pin_i,
   output logic                                    monitor_serial_pin_o,
   output logic                                    monitor_serial_pin_oe_n_o,
   // Mode and clock control.
   output logic                                    monitor_mode_o,
   output logic                                    blank_entry_mode_o,
   output monitor_mode_entry_link_pkg::bus_div_t   bus_div_o,
   output logic                                    osc_halve_bypass_o,
   output logic                                    bus_clock_run_o,
   output logic                                    watchdog_disable_o,
   output logic                                    extra_reset_o,
   output logic [10:0]                             baud_divisor_o,
   // Vector fetch addresses.
   output logic [15:0]                             reset_vector_addr_o,
   output logic [15:0]                             break_vector_addr_o,
   // Received data toward the monitor firmware.
   output logic [7:0]                              rx_byte_o,
   output logic                                    rx_byte_valid_o,
   output logic                                    rx_break_o,
   output logic                                    cmd_ready_o
);
   import monitor_mode_entry_link_pkg::*;

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   logic [`MON_SYNC_W-1:0] pin_vec;
   logic [`MON_SYNC_W-1:0] sync1_q;
   logic [`MON_SYNC_W-1:0] sync2_q;
   logic [`MON_SYNC_W-1:0] sync3_q;
   logic [`MON_SYNC_W-1:0] pin_q;

   assign pin_vec = {entry_strap_low_pin_i, entry_strap_high_pin_i, monitor_serial_pin_i,
                     divider_select_pin_i, entry_interrupt_pin_i, reset_pin_test_voltage_i,
                     entry_interrupt_test_voltage_i, ext_reset_pin_i};

   // Three stages; a filtered bit follows only when stages two and three agree.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
         pin_q   <= '0;
      end else begin
         sync1_q <= pin_vec;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         pin_q   <= (sync2_q & sync3_q) | (pin_q & (sync2_q | sync3_q));
      end
   end

   logic rst_pin;
   logic rst_prev_q;
   logic rst_rise;
   logic test_entry;
   logic blank_entry;
   assign rst_pin  = pin_q[`MON_SYNC_RST];
   assign rst_rise = rst_pin & ~rst_prev_q;
   // Test-voltage entry needs the straps and an idle serial line.
   assign test_entry  = pin_q[`MON_SYNC_IRQ_TST] & pin_q[`MON_SYNC_STRAP_HI] &
                        ~pin_q[`MON_SYNC_STRAP_LO] & pin_q[`MON_SYNC_SERIAL];
   // [R6] straps ignored: erased vector and plain supply level only.
   assign blank_entry = reset_vector_erased_i & ~pin_q[`MON_SYNC_IRQ_TST] &
                        pin_q[`MON_SYNC_IRQ_LVL];

   // ***************************************************************
   // Entry decision
   // ***************************************************************
   logic mode_test_q;
   logic mode_blank_q;
   logic divsel_q;
   logic blank_reset_done_q;

   // [R1] [R20] latch mode, select and vector state together at release.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rst_prev_q         <= 1'b0;
         mode_test_q        <= 1'b0;
         mode_blank_q       <= 1'b0;
         divsel_q           <= 1'b0;
         blank_reset_done_q <= 1'b0;
         extra_reset_o      <= 1'b0;
      end else begin
         rst_prev_q    <= rst_pin;
         extra_reset_o <= 1'b0;
         // [R13] erased-vector mode survives external resets.
         if (rst_rise && !mode_blank_q) begin
            mode_test_q  <= test_entry;
            mode_blank_q <= blank_entry;
            divsel_q     <= pin_q[`MON_SYNC_DIVSEL];
         end
         // [R7] one extra reset after the first erased-vector entry.
         if (rst_rise && !mode_blank_q && blank_entry && !blank_reset_done_q) begin
            extra_reset_o      <= 1'b1;
            blank_reset_done_q <= 1'b1;
         end
      end
   end

   // ***************************************************************
   // Clock, watchdog and vector outputs
   // ***************************************************************
   logic [10:0] bit_time;
   // [R18] baud divisor from mode and select.
   assign bit_time = (mode_test_q && !divsel_q) ? `MON_BAUD_DIV_FAST : `MON_BAUD_DIV_SLOW;

   // Registered mode-derived controls, plus the bus clock run taken from the reset pin.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         monitor_mode_o      <= 1'b0;
         blank_entry_mode_o  <= 1'b0;
         bus_div_o           <= BUS_DIV_4;
         osc_halve_bypass_o  <= 1'b0;
         bus_clock_run_o     <= 1'b0;
         watchdog_disable_o  <= 1'b0;
         baud_divisor_o      <= `MON_BAUD_DIV_SLOW;
         reset_vector_addr_o <= {`MON_PAGE_USER, `MON_RESET_VEC_LO};
         break_vector_addr_o <= {`MON_PAGE_USER, `MON_BREAK_VEC_LO};
      end else begin
         monitor_mode_o     <= mode_test_q | mode_blank_q;
         blank_entry_mode_o <= mode_blank_q;
         // [R3] [R4] divide by four unless test entry with select low.
         bus_div_o          <= (mode_test_q && !divsel_q) ? BUS_DIV_2 : BUS_DIV_4;
         // [R5] halving stage bypassed only for test entry, select low.
         osc_halve_bypass_o <= mode_test_q & ~divsel_q;
         // [R17] bus clock stopped while reset pin is low.
         bus_clock_run_o    <= rst_pin;
         // [R8] [R9] watchdog off permanently or while test voltage stays.
         watchdog_disable_o <= mode_blank_q |
                               (mode_test_q & (pin_q[`MON_SYNC_IRQ_TST] | pin_q[`MON_SYNC_RST_TST]));
         baud_divisor_o     <= bit_time;
         // [R12] alternate vector page in monitor mode.
         reset_vector_addr_o <= {mode_test_q | mode_blank_q ? `MON_PAGE_MONITOR : `MON_PAGE_USER, `MON_RESET_VEC_LO};
         break_vector_addr_o <= {mode_test_q | mode_blank_q ? `MON_PAGE_MONITOR : `MON_PAGE_USER, `MON_BREAK_VEC_LO};
      end
   end

   // ***************************************************************
   // Receiver
   // ***************************************************************
   logic        link_on;
   logic        serial_in;
   logic        tx_busy;
   logic        rx_busy_q;
   logic [10:0] rx_timer_q;
   logic [3:0]  rx_bit_q;
   logic [9:0]  rx_shift_q;
   logic        rx_done;
   logic        rx_is_break;
   // [R17] no link activity while the reset pin is low.
   assign link_on   = rst_pin & (mode_test_q | mode_blank_q);
   assign serial_in = pin_q[`MON_SYNC_SERIAL];
   // Last sample of a frame; the shift holds bits 9..1, new bit enters on top.
   assign rx_done     = rx_busy_q && (rx_timer_q == 11'd0) && (rx_bit_q == `MON_FRAME_BITS - 4'd1);
   // [R15] break is a zero start bit and nine zero bits.
   assign rx_is_break = ~serial_in & ~|rx_shift_q[9:1];

   // [R14] NRZ frame sampled mid-bit at the transmit rate.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rx_busy_q  <= 1'b0;
         rx_timer_q <= 11'd0;
         rx_bit_q   <= 4'd0;
         rx_shift_q <= 10'h000;
      end else if (!link_on || tx_busy) begin
         rx_busy_q <= 1'b0;
      end else if (!rx_busy_q) begin
         if (!serial_in) begin
            rx_busy_q  <= 1'b1;
            rx_timer_q <= {1'b0, bit_time[10:1]} - 11'd1;
            rx_bit_q   <= 4'd0;
         end
      end else if (rx_timer_q != 11'd0) begin
         rx_timer_q <= rx_timer_q - 11'd1;
      end else begin
         rx_shift_q <= {serial_in, rx_shift_q[9:1]};
         rx_timer_q <= bit_time - 11'd1;
         if (rx_bit_q == 4'd0 && serial_in) begin
            rx_busy_q <= 1'b0; // False start bit.
         end else if (rx_done) begin
            rx_busy_q <= 1'b0;
         end else begin
            rx_bit_q <= rx_bit_q + 4'd1;
         end
      end
   end

   // Byte and break pulses toward the firmware.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rx_byte_o       <= 8'h00;
         rx_byte_valid_o <= 1'b0;
         rx_break_o      <= 1'b0;
      end else begin
         rx_byte_valid_o <= rx_done & serial_in;
         rx_break_o      <= rx_done & rx_is_break;
         if (rx_done && serial_in) begin
            rx_byte_o <= rx_shift_q[9:2];
         end
      end
   end

   // ***************************************************************
   // Link sequencer and transmitter
   // ***************************************************************
   link_state_t state_q;
   logic [3:0]  sec_cnt_q;
   logic        sec_done_q;
   logic [3:0]  tx_bits_q;
   logic [10:0] tx_timer_q;
   logic        tx_bit_end;
   assign tx_busy    = (state_q == LINK_SEND_BRK) || (state_q == LINK_HOLD_HIGH);
   assign tx_bit_end = (tx_timer_q == 11'd0);
   // Sequencing of security wait, break send and break echo.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_q    <= LINK_WAIT_SEC;
         sec_cnt_q  <= 4'd0;
         sec_done_q <= 1'b0;
         tx_bits_q  <= 4'd0;
         tx_timer_q <= 11'd0;
      end else if (!link_on) begin
         // Security wait is owed only once per power-on.
         state_q   <= sec_done_q ? LINK_READY : LINK_WAIT_SEC;
         sec_cnt_q <= 4'd0;
      end else begin
         case (state_q)
            LINK_WAIT_SEC: begin
               // [R11] count eight bytes, then announce readiness.
               if (rx_done && serial_in) begin
                  if (sec_cnt_q == `MON_SEC_BYTES - 4'd1) begin
                     sec_done_q <= 1'b1;
                     state_q    <= LINK_SEND_BRK;
                     tx_bits_q  <= `MON_BREAK_BITS - 4'd1;
                     tx_timer_q <= bit_time - 11'd1;
                  end else begin
                     sec_cnt_q <= sec_cnt_q + 4'd1;
                  end
               end
            end
            LINK_READY: begin
               // [R16] a received break starts the high hold.
               if (rx_done && rx_is_break) begin
                  state_q    <= LINK_HOLD_HIGH;
                  tx_bits_q  <= `MON_HOLD_BITS - 4'd1;
                  tx_timer_q <= bit_time - 11'd1;
               end
            end
            LINK_HOLD_HIGH: begin
               if (!tx_bit_end) begin
                  tx_timer_q <= tx_timer_q - 11'd1;
               end else if (tx_bits_q != 4'd0) begin
                  tx_bits_q  <= tx_bits_q - 4'd1;
                  tx_timer_q <= bit_time - 11'd1;
               end else begin
                  // [R16] then echo the break.
                  state_q    <= LINK_SEND_BRK;
                  tx_bits_q  <= `MON_BREAK_BITS - 4'd1;
                  tx_timer_q <= bit_time - 11'd1;
               end
            end
            LINK_SEND_BRK: begin
               // [R11] ten zero bits.
               if (!tx_bit_end) begin
                  tx_timer_q <= tx_timer_q - 11'd1;
               end else if (tx_bits_q != 4'd0) begin
                  tx_bits_q  <= tx_bits_q - 4'd1;
                  tx_timer_q <= bit_time - 11'd1;
               end else begin
                  state_q <= LINK_READY;
               end
            end
            default: begin
               state_q <= LINK_WAIT_SEC;
            end
         endcase
      end
   end

   // [R19] pin drive: released when idle, pulled low for zeros.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         monitor_serial_pin_o      <= 1'b1;
         monitor_serial_pin_oe_n_o <= 1'b1;
         cmd_ready_o               <= 1'b0;
      end else begin
         cmd_ready_o <= link_on & (state_q == LINK_READY);
         // [R16] zeros driven low, hold phase actively driven high.
         monitor_serial_pin_o      <= ~(link_on & (state_q == LINK_SEND_BRK));
         monitor_serial_pin_oe_n_o <= ~(link_on & tx_busy);
      end
   end

endmodule // monitor_mode_entry_link

`default_nettype wire

// ===== rtl/monitor_mode_entry_link_map.svh
`ifndef MONITOR_MODE_ENTRY_LINK_MAP_SVH
`define MONITOR_MODE_ENTRY_LINK_MAP_SVH

// ***************************************************************
// Baud divisors, in crystal clock cycles per bit.
// ***************************************************************
`define MON_BAUD_DIV_SLOW   11'd1024
`define MON_BAUD_DIV_FAST   11'd512

// ***************************************************************
// Link framing counts.
// ***************************************************************
`define MON_SEC_BYTES       4'd8
`define MON_FRAME_BITS      4'd10
`define MON_BREAK_BITS      4'd10
`define MON_HOLD_BITS       4'd2

// ***************************************************************
// Vector pages and vector addresses.
// ***************************************************************
`define MON_PAGE_USER       8'hff
`define MON_PAGE_MONITOR    8'hfe
`define MON_RESET_VEC_LO    8'hfe
`define MON_BREAK_VEC_LO    8'hfc

// ***************************************************************
// Pin synchroniser vector layout.
// ***************************************************************
`define MON_SYNC_W          8
`define MON_SYNC_RST        0
`define MON_SYNC_IRQ_TST    1
`define MON_SYNC_RST_TST    2
`define MON_SYNC_IRQ_LVL    3
`define MON_SYNC_DIVSEL     4
`define MON_SYNC_SERIAL     5
`define MON_SYNC_STRAP_HI   6
`define MON_SYNC_STRAP_LO   7

`endif

// ===== rtl/monitor_mode_entry_link_pkg.sv
package monitor_mode_entry_link_pkg;

   // Link sequencer states.
   typedef enum logic [1:0] {
      LINK_WAIT_SEC  = 2'b00,
      LINK_SEND_BRK  = 2'b01,
      LINK_READY     = 2'b10,
      LINK_HOLD_HIGH = 2'b11
   } link_state_t;

   // Bus clock divide ratio applied to the oscillator input.
   typedef enum logic [1:0] {
      BUS_DIV_NONE = 2'b00,
      BUS_DIV_2    = 2'b01,
      BUS_DIV_4    = 2'b10
   } bus_div_t;

endpackage

// ===== test/monitor_mode_entry_link_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "monitor_mode_entry_link_map.svh"

module monitor_mode_entry_link_checker
   import monitor_mode_entry_link_pkg::*;
(
   // Clock, reset and entry pins.
   input wire logic        clk_i,
   input wire logic        resetn_i,
   input wire logic        ext_reset_pin_i,
   input wire logic        reset_pin_test_voltage_i,
   input wire logic        entry_interrupt_test_voltage_i,
   // Serial drive and receive flags.
   input wire logic        monitor_serial_pin_o,
   input wire logic        monitor_serial_pin_oe_n_o,
   input wire logic        rx_break_o,
   // Mode and clock control.
   input wire logic        monitor_mode_o,
   input wire logic        blank_entry_mode_o,
   input wire bus_div_t    bus_div_o,
   input wire logic        osc_halve_bypass_o,
   input wire logic        bus_clock_run_o,
   input wire logic        watchdog_disable_o,
   input wire logic        extra_reset_o,
   input wire logic [10:0] baud_divisor_o,
   input wire logic [15:0] reset_vector_addr_o,
   input wire logic [15:0] break_vector_addr_o
);
   // ****************************
   // Helpers.
   // ****************************
   logic [15:0] hi_cnt_q;
   logic [15:0] lo_cnt_q;
   wire logic   drv_hi = !monitor_serial_pin_oe_n_o && monitor_serial_pin_o;
   wire logic   drv_lo = !monitor_serial_pin_oe_n_o && !monitor_serial_pin_o;
   wire logic   tv_any = reset_pin_test_voltage_i || entry_interrupt_test_voltage_i;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   // Counts the cycles of one run of high drive.
   always_ff @(posedge clk_i) begin
      if (!resetn_i || !drv_hi) hi_cnt_q <= 16'h0000;
      else hi_cnt_q <= hi_cnt_q + 16'h0001;
   end

   // Counts the cycles of one run of low drive.
   always_ff @(posedge clk_i) begin
      if (!resetn_i || !drv_lo) lo_cnt_q <= 16'h0000;
      else lo_cnt_q <= lo_cnt_q + 16'h0001;
   end

   // ****************************
   // Assertions.
   // ****************************
   // vector page select
   a_vector_page_sel: assert property (
      $stable(monitor_mode_o) && $past(monitor_mode_o, 2) == monitor_mode_o |->
      reset_vector_addr_o == (monitor_mode_o ? 16'hfefe : 16'hfffe) &&
      break_vector_addr_o == (monitor_mode_o ? 16'hfefc : 16'hfffc))
      else $error("vector page does not follow the mode");
   a_blank_div_four: assert property (blank_entry_mode_o && $past(blank_entry_mode_o) |->
      bus_div_o == BUS_DIV_4 && baud_divisor_o == `MON_BAUD_DIV_SLOW)
      else $error("blank entry clocking wrong");
   a_blank_watchdog_off: assert property (blank_entry_mode_o && $past(blank_entry_mode_o) |->
      watchdog_disable_o) else $error("watchdog enabled in blank mode");
   a_blank_mode_sticky: assert property ($past(blank_entry_mode_o, 2) |->
      blank_entry_mode_o && monitor_mode_o) else $error("blank mode left without power-on reset");
   a_reset_stops_clock: assert property (!ext_reset_pin_i [*8] |-> !bus_clock_run_o)
      else $error("bus clock runs with reset pin low");
   a_break_then_hold: assert property (rx_break_o |-> ##[1:3] drv_hi)
      else $error("no high drive after break");
   a_hold_two_bits: assert property ($fell(drv_hi) |->
      hi_cnt_q == {4'h0, baud_divisor_o, 1'b0}) else $error("high hold length wrong");
   a_zero_ten_bits: assert property ($fell(drv_lo) |->
      lo_cnt_q == {2'h0, baud_divisor_o, 3'h0} + {4'h0, baud_divisor_o, 1'b0})
      else $error("break length wrong");
   a_extra_reset_once: assert property (extra_reset_o |=> !extra_reset_o && blank_entry_mode_o)
      else $error("extra reset not a single blank pulse");
   a_bypass_div_two: assert property (
      $stable(bus_div_o) && $stable(osc_halve_bypass_o) && $stable(baud_divisor_o) |->
      osc_halve_bypass_o == (bus_div_o == BUS_DIV_2) &&
      osc_halve_bypass_o == (baud_divisor_o == `MON_BAUD_DIV_FAST))
      else $error("bypass, divide and baud disagree");
   a_test_watchdog_tv: assert property (
      (monitor_mode_o && !blank_entry_mode_o && $stable(tv_any)) [*6] |-> watchdog_disable_o == tv_any)
      else $error("test entry watchdog wrong");

   // Main scenarios reached.
   c_break_seen: cover property (rx_break_o);
   c_extra_reset: cover property (extra_reset_o);
   c_fast_link: cover property (osc_halve_bypass_o && drv_lo);

endmodule // monitor_mode_entry_link_checker

bind monitor_mode_entry_link monitor_mode_entry_link_checker monitor_mode_entry_link_checker_inst (.*);

`default_nettype wire

// ===== test/monitor_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module monitor_host_model #(
   parameter int BIT_CLKS = 512
) (
   // Clock shared with the bench.
   input  wire logic clk_i,
   // Pull-down on the shared serial line.
   output var logic  pull_low_o
);
   // ****************************
   // Host transmitter.
   // ****************************
   initial pull_low_o = 1'b0;

   // LSB first, pull low only
   // Sends one ten-bit frame after an idle gap; the line is released, never driven high.
   task automatic send_frame(input logic [9:0] frame, input int gap);
      repeat (gap + 1) @(negedge clk_i);
      for (int i = 0; i < 10; i++) begin
         pull_low_o = ~frame[i];
         repeat (BIT_CLKS) @(negedge clk_i);
      end
      pull_low_o = 1'b0;
   endtask

endmodule // monitor_host_model

`default_nettype wire

// ===== test/monitor_mode_entry_link_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "monitor_mode_entry_link_map.svh"

module monitor_mode_entry_link_tb;
   import monitor_mode_entry_link_pkg::*;

   // ****************************
   // Wiring and tallies.
   // ****************************
   localparam int BIT = 512;
   logic        clk_i = 1'b0;
   logic        resetn_i, ext_reset_pin_i, reset_pin_test_voltage_i;
   logic        entry_interrupt_pin_i, entry_interrupt_test_voltage_i;
   logic        divider_select_pin_i, entry_strap_high_pin_i;
   logic        entry_strap_low_pin_i, reset_vector_erased_i;
   logic        monitor_serial_pin_o, monitor_serial_pin_oe_n_o, host_pull_low;
   logic        monitor_mode_o, blank_entry_mode_o, osc_halve_bypass_o;
   logic        bus_clock_run_o, watchdog_disable_o, extra_reset_o;
   logic        rx_byte_valid_o, rx_break_o, cmd_ready_o;
   bus_div_t    bus_div_o;
   logic [10:0] baud_divisor_o;
   logic [15:0] reset_vector_addr_o, break_vector_addr_o;
   logic [7:0]  rx_byte_o;
   int          miscompares, checks_done, n_extra, n_valid, n_break, hi_cyc, lo_cyc;
   wire logic   monitor_serial_pin_i = (monitor_serial_pin_oe_n_o | monitor_serial_pin_o) & ~host_pull_low;
   wire logic [4:0] ev = {monitor_serial_pin_oe_n_o, ~monitor_serial_pin_oe_n_o, cmd_ready_o,
                          bus_clock_run_o, monitor_mode_o};

   monitor_mode_entry_link monitor_mode_entry_link_inst (.*);
   monitor_host_model #(.BIT_CLKS(BIT)) monitor_host_model_inst (.clk_i(clk_i), .pull_low_o(host_pull_low));

   always #5 clk_i = ~clk_i;

   // Tallies pulses and the cycles the device drives the line.
   always @(posedge clk_i) begin
      if (extra_reset_o === 1'b1) n_extra++;
      if (rx_byte_valid_o === 1'b1) n_valid++;
      if (rx_break_o === 1'b1) n_break++;
      if (monitor_serial_pin_oe_n_o === 1'b0) begin
         if (monitor_serial_pin_o === 1'b1) hi_cyc++;
         else if (monitor_serial_pin_o === 1'b0) lo_cyc++;
      end
   end

   // ****************************
   // Shared tasks.
   // ****************************
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask

   // Waits a bounded time for one event bit; running out ends the run.
   task automatic wait_for(input int idx, input int lim);
      int i;
      for (i = 0; i < lim && ev[idx] !== 1'b1; i++) @(negedge clk_i);
      if (i >= lim) begin
         miscompares++;
         $display("MISMATCH at %0t: wait %0d timed out", $time, idx);
         finish_test();
      end
   endtask

   task automatic pins(input logic [6:0] v);
      {reset_vector_erased_i, entry_interrupt_pin_i, entry_interrupt_test_voltage_i, divider_select_pin_i,
       entry_strap_high_pin_i, entry_strap_low_pin_i, reset_pin_test_voltage_i} = v;
   endtask

   task automatic por(input int n);
      resetn_i = 1'b0;
      ext_reset_pin_i = 1'b0;
      repeat (n) @(negedge clk_i);
      resetn_i = 1'b1;
      n_extra = 0;
   endtask

   task automatic clr();
      n_valid = 0;
      n_break = 0;
      hi_cyc = 0;
      lo_cyc = 0;
   endtask

   task automatic pin_cycle();
      ext_reset_pin_i = 1'b0;
      repeat (10) @(negedge clk_i);
      check(bus_clock_run_o, 1'b0, "bus clock in reset");
      ext_reset_pin_i = 1'b1;
      wait_for(1, 20);
      repeat (4) @(negedge clk_i);
   endtask

   task automatic expect_mode(input logic mon, blank, byp, wd, input bus_div_t div, input logic [10:0] baud);
      check(monitor_mode_o, mon, "mode");
      check(blank_entry_mode_o, blank, "blank mode");
      check(bus_div_o, div, "bus divide");
      check(osc_halve_bypass_o, byp, "bypass");
      check(watchdog_disable_o, wd, "watchdog off");
      check(baud_divisor_o, baud, "baud");
      check(reset_vector_addr_o, mon ? 16'hfefe : 16'hfffe, "reset vector");
      check(break_vector_addr_o, mon ? 16'hfefc : 16'hfffc, "break vector");
   endtask

   // ****************************
   // Scenarios.
   // ****************************
   task automatic blank_entry();
      por(4);
      pins(7'b1100010);
      pin_cycle();
      expect_mode(1'b1, 1'b1, 1'b0, 1'b1, BUS_DIV_4, `MON_BAUD_DIV_SLOW);
      pins(7'b0000011);
      pin_cycle();
      expect_mode(1'b1, 1'b1, 1'b0, 1'b1, BUS_DIV_4, `MON_BAUD_DIV_SLOW);
      check(n_extra, 1, "extra resets");
   endtask

   task automatic user_entry();
      por(4);
      pins(7'b0100000);
      pin_cycle();
      expect_mode(1'b0, 1'b0, 1'b0, 1'b0, BUS_DIV_4, `MON_BAUD_DIV_SLOW);
   endtask

   task automatic test_entry_slow();
      por(4);
      pins(7'b0111100);
      pin_cycle();
      expect_mode(1'b1, 1'b0, 1'b0, 1'b1, BUS_DIV_4, `MON_BAUD_DIV_SLOW);
      pins(7'b0110001);
      repeat (10) @(negedge clk_i);
      check(baud_divisor_o, `MON_BAUD_DIV_SLOW, "baud after latch");
      pins(7'b0100001);
      repeat (10) @(negedge clk_i);
      check(watchdog_disable_o, 1'b1, "watchdog held");
      pins(7'b0100000);
      repeat (10) @(negedge clk_i);
      check(watchdog_disable_o, 1'b0, "watchdog free");
   endtask

   task automatic test_entry_link();
      logic [63:0] sec = 64'h01_80_a5_00_5a_ff_3c_c3;
      por(4);
      pins(7'b0110100);
      pin_cycle();
      expect_mode(1'b1, 1'b0, 1'b1, 1'b1, BUS_DIV_2, `MON_BAUD_DIV_FAST);
      clr();
      for (int i = 0; i < 7; i++) monitor_host_model_inst.send_frame({1'b1, sec[8*i +: 8], 1'b0}, 3 * i);
      check(hi_cyc + lo_cyc, 0, "early transmit");
      monitor_host_model_inst.send_frame({1'b1, sec[63:56], 1'b0}, 300);
      wait_for(3, 2000);
      wait_for(4, 8000);
      repeat (4) @(negedge clk_i);
      check(lo_cyc, 10 * BIT, "ready break zeros");
      check(hi_cyc, 0, "ready break high");
      check(cmd_ready_o, 1'b1, "ready");
      check(n_valid, 8, "bytes received");
      check(rx_byte_o, 8'h01, "last byte");
      check(n_break, 0, "zero byte no break");
      clr();
      monitor_host_model_inst.send_frame(10'h000, 100);
      wait_for(3, 2000);
      wait_for(4, 8000);
      check(n_break, 1, "break seen");
      check(hi_cyc, 2 * BIT, "hold high");
      check(lo_cyc, 10 * BIT, "break echo");
   endtask

   // Main sequence.
   initial begin
      pins(7'b0100000);
      por(16);
      blank_entry();
      user_entry();
      test_entry_slow();
      test_entry_link();
      finish_test();
   end

endmodule // monitor_mode_entry_link_tb

`default_nettype wire
